/* verilog/lfgfc_pkg.sv */
// Shared constants, timing figures and gamma table of the LED fade and fault controller
package lfgfc_pkg;

    // ****************************************
    // Clock and widths
    // ****************************************
    localparam int CLK_MHZ  = 32'hc8;              // 200 MHz
    localparam int NCH      = 32'h3;               // Output channels
    localparam int NFADE    = 32'h2;               // Channels with fade
    localparam int NDEB     = 32'h3;               // Two enables and the dimming input
    localparam int CNT_W    = 32'h17;              // Debounce and short timers
    localparam int STEP_W   = 32'h20;
    localparam int IDX_W    = 32'h6;
    localparam int LVL_W    = 32'ha;
    localparam int TEMP_W   = 32'h8;
    localparam int KOHM_W   = 32'hc;

    // ****************************************
    // Timing figures and derived cycle counts
    // ****************************************
    localparam int DEBOUNCE_MS           = 32'h25;       // 37 ms
    localparam int DEBOUNCE_CYC          = DEBOUNCE_MS * 32'h3e8 * CLK_MHZ;
    localparam int SHORT_DETECT_MS       = 32'h5;        // 5 ms
    localparam int SHORT_DETECT_CYC      = SHORT_DETECT_MS * 32'h3e8 * CLK_MHZ;
    localparam int FADE_TENTH_US_PER_OHM = 32'h19;       // 2.5 us per ohm
    localparam int FADE_CYC_PER_KOHM     = FADE_TENTH_US_PER_OHM * CLK_MHZ * 32'h64;
    localparam int INSTANT_FADE_US       = 32'h46;       // 70 us
    localparam int INSTANT_FADE_CYC      = INSTANT_FADE_US * CLK_MHZ;
    localparam int GAMMA_LAST            = 32'h3e;       // 62 steps between 63 levels
    localparam int STEP_CYC_PER_KOHM     = FADE_CYC_PER_KOHM / GAMMA_LAST;
    localparam int INSTANT_STEP_CYC      = INSTANT_FADE_CYC / GAMMA_LAST;
    localparam int PWM_FREQ_HZ           = 32'hdc;       // 220 Hz
    localparam int PWM_TICK_CYC          = (CLK_MHZ * 32'hf4240) / (PWM_FREQ_HZ * 32'h3e8);

    // ****************************************
    // Levels and thermal thresholds
    // ****************************************
    localparam logic [IDX_W-1:0]  IDX_TOP        = 6'h3e;
    localparam logic [LVL_W-1:0]  LVL_FULL       = 10'h3e8;   // 1000 per mille
    localparam logic [LVL_W-1:0]  PHASE_LAST     = 10'h3e7;
    localparam logic [LVL_W-1:0]  PWM_TICK_LAST  = LVL_W'(PWM_TICK_CYC - 1);
    localparam logic [TEMP_W-1:0] TEMP_ROLLBACK  = 8'h91;     // 145 C
    localparam logic [TEMP_W-1:0] TEMP_SHUTDOWN  = 8'haf;     // 175 C
    localparam logic [15:0]       ROLL_PER_C     = 16'h26;    // 3.8 % per C in per mille
    localparam logic [15:0]       ROLL_FLOOR     = 16'h32;    // 5 % in per mille
    localparam logic [15:0]       ROLL_FULL      = 16'h3e8;

    // Gamma corrected intensity, per mille of full current
    localparam logic [LVL_W-1:0] GAMMA [0:62] = '{
        10'h000, 10'h002, 10'h004, 10'h006, 10'h008, 10'h00a, 10'h00c, 10'h010,
        10'h014, 10'h018, 10'h01c, 10'h020, 10'h024, 10'h02a, 10'h030, 10'h036,
        10'h03c, 10'h042, 10'h048, 10'h050, 10'h058, 10'h060, 10'h068, 10'h070,
        10'h078, 10'h082, 10'h08c, 10'h096, 10'h0a0, 10'h0aa, 10'h0b4, 10'h0c2,
        10'h0d0, 10'h0de, 10'h0ec, 10'h0fa, 10'h108, 10'h11a, 10'h12c, 10'h13e,
        10'h150, 10'h162, 10'h174, 10'h18a, 10'h1a0, 10'h1b6, 10'h1cc, 10'h1e2,
        10'h1f8, 10'h216, 10'h234, 10'h252, 10'h270, 10'h28e, 10'h2ac, 10'h2d2,
        10'h2f8, 10'h31e, 10'h344, 10'h36a, 10'h392, 10'h3bc, 10'h3e8
    };

    function automatic logic [LVL_W-1:0] gamma_level(input logic [IDX_W-1:0] idx);
        gamma_level = (idx > IDX_TOP) ? LVL_FULL : GAMMA[idx];
    endfunction

endpackage

/* verilog/lfgfc_short_if.sv */
// Output-low comparator levels and short fault flags between controller and detector
`timescale 1ns/1ps
interface lfgfc_short_if;
    logic [lfgfc_pkg::NCH-1:0] outLow;
    logic [lfgfc_pkg::NCH-1:0] shortFault;
    modport det (input outLow, output shortFault);
    modport ctl (output outLow, input shortFault);
endinterface

/* verilog/lfgfc_debounce.sv */
// Debouncer for the two channel enables and the shared dimming input
`timescale 1ns/1ps
module lfgfc_debounce #(
    parameter int CYCLES = lfgfc_pkg::DEBOUNCE_CYC
) (
    // Clock and reset
    input  logic                       clock,
    input  logic                       resetn,
    // Raw and settled levels
    input  logic [lfgfc_pkg::NDEB-1:0] rawIn,
    output logic [lfgfc_pkg::NDEB-1:0] stableOut
);
    typedef struct packed {
        logic [lfgfc_pkg::NDEB-1:0]                       stable;
        logic [lfgfc_pkg::NDEB-1:0][lfgfc_pkg::CNT_W-1:0] cnt;
    } lfgfc_deb_t;

    localparam logic [lfgfc_pkg::CNT_W-1:0] CNT_LAST = lfgfc_pkg::CNT_W'(CYCLES - 1);

    lfgfc_deb_t state_reg;
    lfgfc_deb_t state_next;

    always_comb begin
        state_next = state_reg;
        for (int i = 0; i < lfgfc_pkg::NDEB; i++) begin
            if (rawIn[i] == state_reg.stable[i]) begin
                state_next.cnt[i] = '0;
            end else if (state_reg.cnt[i] == CNT_LAST) begin
                state_next.stable[i] = rawIn[i];
                state_next.cnt[i]    = '0;
            end else begin
                state_next.cnt[i] = state_reg.cnt[i] + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign stableOut = state_reg.stable;

    property p_deb_hold;
        @(posedge clock) disable iff (!resetn)
        state_reg.cnt[0] != CNT_LAST |=> $stable(state_reg.stable[0]);
    endproperty
    a_deb_hold: assert property (p_deb_hold) else $error("enable changed before debounce");

endmodule // lfgfc_debounce

/* verilog/lfgfc_short_det.sv */
// Short-to-ground detector: output held low for the detection time raises a fault
`timescale 1ns/1ps
module lfgfc_short_det #(
    parameter int CYCLES = lfgfc_pkg::SHORT_DETECT_CYC
) (
    // Clock and reset
    input  logic         clock,
    input  logic         resetn,
    // Comparator levels in, fault flags out
    lfgfc_short_if.det   det
);
    typedef struct packed {
        logic [lfgfc_pkg::NCH-1:0]                       fault;
        logic [lfgfc_pkg::NCH-1:0][lfgfc_pkg::CNT_W-1:0] cnt;
    } lfgfc_sd_t;

    localparam logic [lfgfc_pkg::CNT_W-1:0] CNT_LAST = lfgfc_pkg::CNT_W'(CYCLES - 1);

    lfgfc_sd_t state_reg;
    lfgfc_sd_t state_next;

    always_comb begin
        state_next = state_reg;
        for (int i = 0; i < lfgfc_pkg::NCH; i++) begin
            if (!det.outLow[i]) begin
                state_next.fault[i] = 1'b0;
                state_next.cnt[i]   = '0;
            end else if (state_reg.cnt[i] == CNT_LAST) begin
                state_next.fault[i] = 1'b1;
            end else begin
                state_next.cnt[i] = state_reg.cnt[i] + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign det.shortFault = state_reg.fault;

    property p_sd_set;
        @(posedge clock) disable iff (!resetn)
        $rose(state_reg.fault[0]) |-> $past(state_reg.cnt[0]) == CNT_LAST;
    endproperty
    a_sd_set: assert property (p_sd_set) else $error("short flagged too early");

    property p_sd_clear;
        @(posedge clock) disable iff (!resetn)
        !det.outLow[0] |=> !state_reg.fault[0];
    endproperty
    a_sd_clear: assert property (p_sd_clear) else $error("short not released");

endmodule // lfgfc_short_det

/* verilog/lfgfc_top.sv */
// LED fade, undervoltage, short and thermal controller for a three-channel linear driver
`timescale 1ns/1ps
module lfgfc_top #(
    parameter int DEBOUNCE_CYCLES = lfgfc_pkg::DEBOUNCE_CYC,
    parameter int SHORT_CYCLES    = lfgfc_pkg::SHORT_DETECT_CYC,
    parameter int STEP_PER_KOHM   = lfgfc_pkg::STEP_CYC_PER_KOHM
) (
    // Clock and reset
    input  logic                          clock,
    input  logic                          resetn,
    // Switch inputs: bits 0 and 1 fade, bit 2 direct
    input  logic [lfgfc_pkg::NCH-1:0]     channelEnableInputs,
    input  logic                          dimmingIn,
    // Fade time programming in kilo-ohm, zero when grounded
    input  logic [lfgfc_pkg::KOHM_W-1:0]  fadeUpTimeSet,
    input  logic [lfgfc_pkg::KOHM_W-1:0]  fadeDownTimeSet,
    // Supply comparators
    input  logic                          supplyBelowUpper,
    input  logic                          supplyBelowLower,
    input  logic                          supplyAboveRecover,
    // Die temperature in degrees C
    input  logic [lfgfc_pkg::TEMP_W-1:0]  dieTempC,
    // Output voltage below the short detect threshold
    input  logic [lfgfc_pkg::NCH-1:0]     outBelowShortThreshold,
    // Current source controls
    output logic [lfgfc_pkg::NCH-1:0]     ledChannelOutputs,
    output logic [lfgfc_pkg::NCH-1:0]     currentClamp,
    output logic [lfgfc_pkg::LVL_W-1:0]   currentScale,
    // Open-drain fault flag
    input  logic                          faultFlagNIn,
    output logic                          faultFlagNOut,
    output logic                          faultFlagNOe
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [lfgfc_pkg::NFADE-1:0]                          enLatch;
        logic [lfgfc_pkg::NDEB-1:0]                           debPrev;
        logic                                                 lockout;
        logic                                                 thermShut;
        logic [lfgfc_pkg::NFADE-1:0][lfgfc_pkg::IDX_W-1:0]    idx;
        logic [lfgfc_pkg::NFADE-1:0][lfgfc_pkg::STEP_W-1:0]   stepCnt;
        logic [lfgfc_pkg::LVL_W-1:0]                          pwmTick;
        logic [lfgfc_pkg::LVL_W-1:0]                          pwmPhase;
        logic [lfgfc_pkg::NCH-1:0]                            ledOn;
        logic [lfgfc_pkg::NCH-1:0]                            clamp;
        logic [lfgfc_pkg::LVL_W-1:0]                          scale;
        logic                                                 faultOe;
    } lfgfc_state_t;

    lfgfc_state_t                 state_reg;
    lfgfc_state_t                 state_next;
    logic [lfgfc_pkg::NDEB-1:0]   debounced;
    logic [lfgfc_pkg::NFADE-1:0]  enEvt;
    logic                         dimEvt;
    logic                         faultSense;

    lfgfc_short_if shortIf ();

    // Cycles per gamma step for a programming value
    function automatic logic [lfgfc_pkg::STEP_W-1:0] step_limit(
        input logic [lfgfc_pkg::KOHM_W-1:0] kohm
    );
        if (kohm == '0) begin
            step_limit = lfgfc_pkg::STEP_W'(lfgfc_pkg::INSTANT_STEP_CYC);
        end else begin
            step_limit = lfgfc_pkg::STEP_W'(kohm) * lfgfc_pkg::STEP_W'(STEP_PER_KOHM);
        end
    endfunction

    // ****************************************
    // Submodules
    // ****************************************
    // Debounce runs whatever the fade settings are
    lfgfc_debounce #(
        .CYCLES    (DEBOUNCE_CYCLES)
    ) uDebounce (
        .clock     (clock),
        .resetn    (resetn),
        .rawIn     ({dimmingIn, channelEnableInputs[1:0]}),
        .stableOut (debounced)
    );

    assign shortIf.outLow = outBelowShortThreshold;

    lfgfc_short_det #(
        .CYCLES (SHORT_CYCLES)
    ) uShortDet (
        .clock  (clock),
        .resetn (resetn),
        .det    (shortIf)
    );

    assign enEvt  = debounced[1:0] ^ state_reg.debPrev[1:0];
    assign dimEvt = debounced[2] ^ state_reg.debPrev[2];

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [lfgfc_pkg::STEP_W-1:0] limit;
        logic [15:0]                  drop;
        logic                         runOk;
        limit      = '0;
        drop       = '0;
        runOk      = 1'b0;
        state_next = state_reg;
        state_next.debPrev = debounced;

        // Undervoltage lockout with hysteresis
        if (supplyBelowUpper) begin
            state_next.lockout = 1'b1;
        end else if (supplyAboveRecover) begin
            state_next.lockout = 1'b0;
        end

        // Thermal shutdown latch
        if (dieTempC > lfgfc_pkg::TEMP_SHUTDOWN) begin
            state_next.thermShut = 1'b1;
        end else if (dieTempC < lfgfc_pkg::TEMP_ROLLBACK) begin
            state_next.thermShut = 1'b0;
        end

        // Enable latches: own enable first, shared dimming otherwise
        for (int ch = 0; ch < lfgfc_pkg::NFADE; ch++) begin
            if (enEvt[ch]) begin
                state_next.enLatch[ch] = debounced[ch];
            end else if (dimEvt) begin
                state_next.enLatch[ch] = debounced[2];
            end
        end
        if (state_next.thermShut) begin
            state_next.enLatch = '0;
        end

        // Fade ramp, one gamma index per step interval
        for (int ch = 0; ch < lfgfc_pkg::NFADE; ch++) begin
            limit = state_next.enLatch[ch] ? step_limit(fadeUpTimeSet)
                                           : step_limit(fadeDownTimeSet);
            if ((state_next.enLatch[ch] && state_reg.idx[ch] != lfgfc_pkg::IDX_TOP) ||
                (!state_next.enLatch[ch] && state_reg.idx[ch] != '0)) begin
                if (state_reg.stepCnt[ch] >= limit - 1'b1) begin
                    state_next.stepCnt[ch] = '0;
                    if (state_next.enLatch[ch]) begin
                        state_next.idx[ch] = state_reg.idx[ch] + 1'b1;
                    end else begin
                        state_next.idx[ch] = state_reg.idx[ch] - 1'b1;
                    end
                end else begin
                    state_next.stepCnt[ch] = state_reg.stepCnt[ch] + 1'b1;
                end
            end else begin
                state_next.stepCnt[ch] = '0;
            end
        end

        // Deep undervoltage drops back to power-on default
        if (supplyBelowLower) begin
            state_next.enLatch = '0;
            state_next.idx     = '0;
            state_next.stepCnt = '0;
        end

        // Internal PWM: 1000 phases per period
        if (state_reg.pwmTick == lfgfc_pkg::PWM_TICK_LAST) begin
            state_next.pwmTick  = '0;
            state_next.pwmPhase = (state_reg.pwmPhase == lfgfc_pkg::PHASE_LAST) ? '0
                                : state_reg.pwmPhase + 1'b1;
        end else begin
            state_next.pwmTick = state_reg.pwmTick + 1'b1;
        end

        // Thermal rollback in per mille of nominal current
        if (dieTempC <= lfgfc_pkg::TEMP_ROLLBACK) begin
            state_next.scale = lfgfc_pkg::LVL_FULL;
        end else begin
            drop = (16'(dieTempC) - 16'(lfgfc_pkg::TEMP_ROLLBACK)) * lfgfc_pkg::ROLL_PER_C;
            if (drop > lfgfc_pkg::ROLL_FULL - lfgfc_pkg::ROLL_FLOOR) begin
                state_next.scale = '0;
            end else begin
                state_next.scale = lfgfc_pkg::LVL_W'(lfgfc_pkg::ROLL_FULL - drop);
            end
        end

        // Output gating
        runOk = !state_next.lockout && !state_next.thermShut && state_next.scale != '0;
        for (int ch = 0; ch < lfgfc_pkg::NFADE; ch++) begin
            state_next.ledOn[ch] = runOk && (state_next.pwmPhase <
                                   lfgfc_pkg::gamma_level(state_next.idx[ch]));
        end
        state_next.ledOn[2] = runOk && channelEnableInputs[2];

        // Short clamp and fault flag
        state_next.clamp   = shortIf.shortFault;
        state_next.faultOe = (|shortIf.shortFault) || state_next.thermShut;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign ledChannelOutputs = state_reg.ledOn;
    assign currentClamp      = state_reg.clamp;
    assign currentScale      = state_reg.scale;
    assign faultFlagNOut     = 1'b0;
    assign faultFlagNOe      = state_reg.faultOe;
    assign faultSense        = faultFlagNIn;

    // ****************************************
    // Checks
    // ****************************************
    property p_uv_off;
        @(posedge clock) disable iff (!resetn)
        supplyBelowUpper |=> state_reg.ledOn == '0;
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("sources on in lockout");

    property p_uv_keep;
        @(posedge clock) disable iff (!resetn)
        supplyBelowUpper && !supplyBelowLower && debounced == state_reg.debPrev &&
        !state_reg.thermShut && dieTempC <= lfgfc_pkg::TEMP_SHUTDOWN
        |=> $stable(state_reg.enLatch);
    endproperty
    a_uv_keep: assert property (p_uv_keep) else $error("latch lost in lockout");

    property p_uv_reset;
        @(posedge clock) disable iff (!resetn)
        supplyBelowLower |=> state_reg.enLatch == '0 && state_reg.idx == '0;
    endproperty
    a_uv_reset: assert property (p_uv_reset) else $error("latch kept below lower");

    property p_recover;
        @(posedge clock) disable iff (!resetn)
        state_reg.lockout && !supplyAboveRecover |=> state_reg.lockout;
    endproperty
    a_recover: assert property (p_recover) else $error("lockout left early");

    property p_prec;
        @(posedge clock) disable iff (!resetn)
        enEvt[0] && dimEvt && !supplyBelowLower && dieTempC < lfgfc_pkg::TEMP_ROLLBACK
        |=> state_reg.enLatch[0] == $past(debounced[0]);
    endproperty
    a_prec: assert property (p_prec) else $error("dimming beat enable");

    property p_step;
        @(posedge clock) disable iff (!resetn)
        $changed(state_reg.idx[0]) |-> state_reg.idx[0] == $past(state_reg.idx[0]) + 1'b1 ||
        state_reg.idx[0] == $past(state_reg.idx[0]) - 1'b1 || state_reg.idx[0] == '0;
    endproperty
    a_step: assert property (p_step) else $error("fade index jumped");

    property p_top;
        @(posedge clock) disable iff (!resetn)
        state_reg.idx[0] == lfgfc_pkg::IDX_TOP && state_reg.enLatch[0] &&
        debounced == state_reg.debPrev && !state_reg.lockout && !supplyBelowUpper &&
        !state_reg.thermShut && dieTempC < lfgfc_pkg::TEMP_ROLLBACK
        |=> state_reg.ledOn[0];
    endproperty
    a_top: assert property (p_top) else $error("full level not continuous");

    property p_clamp;
        @(posedge clock) disable iff (!resetn)
        shortIf.shortFault[0] |=> state_reg.clamp[0] && faultFlagNOe;
    endproperty
    a_clamp: assert property (p_clamp) else $error("short not reported");

    property p_roll;
        @(posedge clock) disable iff (!resetn)
        dieTempC > lfgfc_pkg::TEMP_ROLLBACK + 8'h19 |=> currentScale == '0 &&
        ledChannelOutputs == '0;
    endproperty
    a_roll: assert property (p_roll) else $error("rollback floor missed");

    property p_shut;
        @(posedge clock) disable iff (!resetn)
        dieTempC > lfgfc_pkg::TEMP_SHUTDOWN |=> ledChannelOutputs == '0 && faultFlagNOe;
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown not taken");

    property p_block;
        @(posedge clock) disable iff (!resetn)
        state_reg.thermShut && dieTempC >= lfgfc_pkg::TEMP_ROLLBACK
        |=> state_reg.thermShut && state_reg.enLatch == '0;
    endproperty
    a_block: assert property (p_block) else $error("restart while hot");

    property p_od;
        @(posedge clock) disable iff (!resetn)
        faultFlagNOe |-> !faultFlagNOut;
    endproperty
    a_od: assert property (p_od) else $error("fault flag driven high");

    c_full: cover property (@(posedge clock) disable iff (!resetn)
        state_reg.idx[0] == lfgfc_pkg::IDX_TOP);
    c_short: cover property (@(posedge clock) disable iff (!resetn)
        $rose(state_reg.clamp[0]));
    c_shut: cover property (@(posedge clock) disable iff (!resetn)
        $fell(state_reg.thermShut) && faultSense);
    c_uvreset: cover property (@(posedge clock) disable iff (!resetn)
        supplyBelowLower && $past(state_reg.enLatch) != '0);

endmodule // lfgfc_top

/* tb/lfgfc_switch_model.sv */
// Far-side model: switch levels and the pulled-up fault line
`timescale 1ns/1ps
module lfgfc_switch_model (
    // Switch levels from the bench
    input  logic [2:0] swLevel,
    output logic [2:0] enPins,
    // Fault pin
    input  logic       faultOe,
    input  logic       faultOut,
    output logic       faultPin
);
    assign enPins   = swLevel;
    assign faultPin = faultOe ? faultOut : 1'b1;
endmodule // lfgfc_switch_model

/* tb/testbench.sv */
// Self-checking bench of the LED fade and fault controller
`timescale 1ns/1ps
module testbench;
    logic        clock, resetn, dim, uvUp, uvLow, uvRec, fPin, fOut, fOe;
    logic [2:0]  sw, en, below, ledOut, clamp;
    logic [11:0] tUp, tDn;
    logic [7:0]  temp;
    logic [9:0]  scale;
    int          fail_count = 0;
    int          cmp_count = 0;

    lfgfc_top #(.DEBOUNCE_CYCLES(8), .SHORT_CYCLES(8), .STEP_PER_KOHM(2)) i_lfgfc_top (
        .clock(clock), .resetn(resetn), .channelEnableInputs(en), .dimmingIn(dim),
        .fadeUpTimeSet(tUp), .fadeDownTimeSet(tDn), .supplyBelowUpper(uvUp),
        .supplyBelowLower(uvLow), .supplyAboveRecover(uvRec), .dieTempC(temp),
        .outBelowShortThreshold(below), .ledChannelOutputs(ledOut), .currentClamp(clamp),
        .currentScale(scale), .faultFlagNIn(fPin), .faultFlagNOut(fOut), .faultFlagNOe(fOe));
    lfgfc_switch_model i_lfgfc_switch_model (.swLevel(sw), .enPins(en), .faultOe(fOe),
        .faultOut(fOut), .faultPin(fPin));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic end_of_test;
        $display("mismatches %0d of %0d compares", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_uv;
        sw = 3'h4;
        cyc(3);
        chk(ledOut, 3'h4);
        uvUp = 1'b1;
        uvRec = 1'b0;
        cyc(2);
        chk(ledOut, 3'h0);
        uvUp = 1'b0;
        cyc(3);
        chk(ledOut, 3'h0);
        uvRec = 1'b1;
        cyc(3);
        chk(ledOut, 3'h4);
    endtask
    task automatic t_therm;
        temp = 8'h96;
        cyc(3);
        chk(scale, 10'h32a);
        temp = 8'hab;
        cyc(3);
        chk(ledOut, 3'h0);
        temp = 8'hb4;
        cyc(3);
        chk({ledOut, fOe, fPin}, 5'h02);
        temp = 8'ha0;
        cyc(3);
        chk({ledOut, fOe}, 4'h1);
        temp = 8'h64;
        cyc(3);
        chk({ledOut, fOe, fPin}, 5'h11);
    endtask
    task automatic t_short;
        below = 3'h4;
        cyc(7);
        chk(clamp, 3'h0);
        cyc(4);
        chk({clamp, fOe, fPin}, 5'h12);
        below = 3'h0;
        cyc(4);
        chk({clamp, fOe, fPin}, 5'h01);
    endtask
    task automatic t_fade;
        sw = 3'h5;
        cyc(15000);
        chk(ledOut[0], 1'b1);
        {uvUp, uvLow} = 2'h3;
        cyc(2);
        {uvUp, uvLow} = 2'h0;
        cyc(2);
        chk(ledOut[1:0], 2'h0);
        dim = 1'b1;
        cyc(15000);
        chk(ledOut[1:0], 2'h3);
        sw = 3'h4;
        cyc(15000);
        chk(ledOut[1:0], 2'h2);
        tDn = 12'h3e8;
        sw  = 3'h5;
        dim = 1'b0;
        cyc(15000);
        chk(ledOut[0], 1'b1);
        chk(ledOut[1], 1'b1);
    endtask

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        #400000;
        fail_count++;
        end_of_test;
    end
    initial begin
        {resetn, sw, dim, uvUp, uvLow, uvRec, below, tUp, tDn} = '0;
        uvRec = 1'b1;
        temp = 8'h19;
        cyc(10);
        chk({ledOut, clamp, fOe}, 7'h00);
        resetn = 1'b1;
        cyc(2);
        chk(scale, 10'h3e8);
        t_uv;
        t_therm;
        t_short;
        t_fade;
        end_of_test;
    end
endmodule // testbench
